// >>> include/rxqt_pkg.sv
/*
 * rxqt_pkg: constants, register map, field layout and types for the
 * receive quality and timeout block.
 * Assumes a 20 MHz system clock and an APB master with 32-bit data.
 */
`default_nettype none
package rxqt_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned TICK_NS = 1000;                 // timer unit, 1 us
    localparam int unsigned TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned DCLK_LOW_NS = 250;              // data clock low time
    localparam int unsigned DCLK_LOW_CYC = (DCLK_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam longint unsigned FDIG_HZ = 64'd20000000;
    // ------------------------------------------------------------
    // intermediate frequency arithmetic
    // ------------------------------------------------------------
    localparam longint unsigned IF_DIV = 64'd12;
    localparam longint unsigned IF_BASE = 64'd100;
    localparam int unsigned IF_SHIFT = 11;
    // ------------------------------------------------------------
    // quality indicator constants
    // ------------------------------------------------------------
    localparam logic [8:0] LEVEL_DBM_OFS = 9'h092;        // code 0 is -146 dBm
    localparam logic [8:0] CS_HYST = 9'h003;
    localparam logic [7:0] CS_DYN_STEP = 8'h06;
    localparam logic [7:0] PQI_INC = 8'h01;
    localparam logic [7:0] PQI_DEC = 8'h04;
    localparam logic [7:0] PQI_MAX = 8'hff;
    // ------------------------------------------------------------
    // register map (byte addresses) and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_THRESH = 8'h04;
    localparam logic [7:0] A_TIMER = 8'h08;
    localparam logic [7:0] A_IFOFS = 8'h0c;
    localparam logic [7:0] A_LEVEL = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_IF_ANA = 8'h18;
    localparam logic [7:0] A_IF_DIG = 8'h1c;
    localparam logic [5:0] SYNC_WORD_LENGTH_RST = 6'h20;
    localparam logic [15:0] TIMER_RST = 16'h0000;
    // status bit positions, ST_PV to ST_OVF write one to clear, ST_CS follows carrier detect
    localparam int unsigned ST_CS = 0;
    localparam int unsigned ST_PV = 1;
    localparam int unsigned ST_SV = 2;
    localparam int unsigned ST_TO = 3;
    localparam int unsigned ST_OVF = 4;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        TMR_IDLE = 2'b00,
        TMR_RUN = 2'b01,
        TMR_HALT = 2'b10,
        TMR_NEVER = 2'b11
    } rxqt_tmr_e;
    typedef enum logic [1:0] {
        DM_PACKET = 2'b00,
        DM_FIFO = 2'b01,
        DM_GPIO = 2'b10
    } rxqt_dmode_e;
    // demodulator side inputs, all on the system clock
    typedef struct packed {
        logic [7:0] level;        // level filter output
        logic level_valid;
        logic bit_valid;
        logic bit_val;
        logic [5:0] corr;         // sync correlation
        logic corr_sec;           // correlation is for secondary word
        logic corr_valid;
        logic sync_done;          // end of sync word detection
    } rxqt_demod_s;
endpackage
`default_nettype wire

// >>> rtl/rxqt_core.sv
/*
 * rxqt_core: receive quality indicators, rx timer with stop logic,
 * raw receive data modes and IF offset registers behind an APB slave.
 * Assumes demodulator inputs are synchronous to clk_sys_in.
 */
// Behaviour
// R1: IF equals reference/12 times (offset+100) over 2^11, analog and digital.
// R2: rx timer stop is a configurable AND/OR of sync, carrier and preamble.
// R3: timer expiry aborts reception and discards the packet.
// R4: select 0 with no masks: timeout never expires.
// R5: select 1 with no masks: timer runs from rx entry and expires.
// R6: one mask stops on that indicator alone; sync mask is the default.
// R7: several masks with select 0 need all indicators together.
// R8: several masks with select 1 need any one indicator.
// R9: host keeps sync check in the stop set or leaves rx by abort.
// R10: fifo mode writes raw bytes to the rx fifo; host avoids overflow.
// R11: gpio mode drives raw bits with data clock, updated on falling edge.
// R12: signal level is unsigned 1 dB code, dBm is code minus 146.
// R13: captured level latches at sync end, abort command or timeout.
// R14: running level follows the filter; host may stream it over spi.
// R15: static mode asserts above threshold, releases 3 dB below it.
// R16: dynamic modes need a 6, 12 or 18 dB rise, release on equal fall.
// R17: carrier detect starts frequency and timing tracking and feeds lbt.
// R18: preamble count up 1 per inversion, down 4 per repetition, peak kept.
// R19: preamble valid once peak passes four times its threshold.
// R20: sync valid once peak reaches length minus twice threshold.
// R21: peak correlation in low six bits, bit 6 marks secondary word.
// R22: once stop condition holds, the timer halts for that packet.
`timescale 1ns/1ps
`default_nettype none
module rxqt_core #(
    parameter longint unsigned XO_HZ = 64'd50000000
) (
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic [7:0] paddr_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic rx_active_in,
    input wire logic abort_command_in,
    input wire rxqt_pkg::rxqt_demod_s demod_in,
    input wire logic fifo_full_in,
    output logic fifo_wr_out,
    output logic [7:0] fifo_data_out,
    output logic gpio_data_out,
    output logic gpio_clk_out,
    output logic carrier_detect_out,
    output logic track_start_out,
    output logic preamble_valid_out,
    output logic sync_valid_out,
    output logic rx_timeout_abort_out,
    output logic [7:0] analog_if_offset_out,
    output logic [7:0] digital_if_offset_out
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic and_or;
        logic cs_m;
        logic sqi_m;
        logic pqi_m;
        logic [1:0] cs_mode;
        logic sync_quality_check_enable;
        logic [1:0] dmode;
        logic [7:0] level_th;
        logic [3:0] preamble_quality_threshold;
        logic [2:0] sync_quality_threshold;
        logic [5:0] sync_word_length;
        logic [15:0] dur;
        logic [7:0] if_ana;
        logic [7:0] if_dig;
        logic [31:0] prdata;
        logic rx_d;
        logic cs;
        logic [7:0] cs_ref;
        logic track;
        logic last_bit;
        logic [7:0] pqi_cnt;
        logic [7:0] pqi_peak;
        logic pv;
        logic [5:0] sqi_peak;
        logic sqi_sec;
        logic sv;
        logic [4:0] st;
        logic [7:0] cap_level;
        rxqt_pkg::rxqt_tmr_e tmr;
        logic [4:0] tick_cnt;
        logic [15:0] tmr_cnt;
        logic abort;
        logic [7:0] sh;
        logic [2:0] sh_cnt;
        logic fifo_wr;
        logic [7:0] fifo_data;
        logic gdata;
        logic gclk;
        logic [2:0] gcnt;
    } rxqt_state_s;

    rxqt_state_s q, d;
    logic [1:0] rst_sync_q;
    logic rst_n;
    logic rx_rise, tick, any_mask, stop_cond;
    logic [31:0] if_ana_hz, if_dig_hz;
    logic [6:0] sqi_need;

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    // two-stage release of the async reset
    always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // derived terms
    // ------------------------------------------------------------
    // intermediate frequency in hertz, see R1
    assign if_ana_hz = 32'((XO_HZ * (64'(q.if_ana) + rxqt_pkg::IF_BASE))
        / (rxqt_pkg::IF_DIV << rxqt_pkg::IF_SHIFT));
    assign if_dig_hz = 32'((rxqt_pkg::FDIG_HZ * (64'(q.if_dig) + rxqt_pkg::IF_BASE))
        / (rxqt_pkg::IF_DIV << rxqt_pkg::IF_SHIFT));
    assign rx_rise = rx_active_in & ~q.rx_d;
    assign tick = (q.tick_cnt == 5'd0);
    assign any_mask = q.cs_m | q.sqi_m | q.pqi_m;
    // and of selected terms or or of selected terms, see R2 R6 R7 R8
    assign stop_cond = any_mask & (q.and_or
        ? ((q.cs_m & q.cs) | (q.sqi_m & q.sv) | (q.pqi_m & q.pv))
        : ((~q.cs_m | q.cs) & (~q.sqi_m | q.sv) & (~q.pqi_m | q.pv)));
    // sync length minus twice the threshold, see R20
    assign sqi_need = {1'b0, q.sync_word_length} - {3'b000, q.sync_quality_threshold, 1'b0};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [8:0] lvl;
        logic [8:0] step;
        logic [7:0] cnt;
        d = q;
        lvl = {1'b0, demod_in.level};
        step = {1'b0, 8'(q.cs_mode * rxqt_pkg::CS_DYN_STEP)};
        cnt = q.pqi_cnt;
        d.track = 1'b0;
        d.abort = 1'b0;
        d.fifo_wr = 1'b0;
        d.rx_d = rx_active_in;
        d.tick_cnt = tick ? 5'(rxqt_pkg::TICK_CYC - 1) : q.tick_cnt - 5'd1;
        // apb read data captured in the setup cycle
        if (psel_in && !penable_in) begin
            if (paddr_in == rxqt_pkg::A_CTRL) begin
                d.prdata = {23'h0, q.dmode, q.sync_quality_check_enable, q.cs_mode, q.pqi_m, q.sqi_m,
                    q.cs_m, q.and_or};
            end else if (paddr_in == rxqt_pkg::A_THRESH) begin
                d.prdata = {10'h0, q.sync_word_length, 1'b0, q.sync_quality_threshold, q.preamble_quality_threshold, q.level_th};
            end else if (paddr_in == rxqt_pkg::A_TIMER) begin
                d.prdata = {16'h0, q.dur};
            end else if (paddr_in == rxqt_pkg::A_IFOFS) begin
                d.prdata = {16'h0, q.if_dig, q.if_ana};
            end else if (paddr_in == rxqt_pkg::A_LEVEL) begin
                // running level taken straight from the filter, see R12 R14 R21
                d.prdata = {1'b0, q.sqi_sec, q.sqi_peak[5:0], q.pqi_peak,
                    demod_in.level, q.cap_level};
            end else if (paddr_in == rxqt_pkg::A_STATUS) begin
                d.prdata = {25'h0, q.tmr, q.st};
            end else if (paddr_in == rxqt_pkg::A_IF_ANA) begin
                d.prdata = if_ana_hz;
            end else if (paddr_in == rxqt_pkg::A_IF_DIG) begin
                d.prdata = if_dig_hz;
            end else begin
                d.prdata = 32'h0;
            end
        end
        // apb writes in the access phase
        if (psel_in && penable_in && pwrite_in) begin
            if (paddr_in == rxqt_pkg::A_CTRL) begin
                {d.dmode, d.sync_quality_check_enable, d.cs_mode, d.pqi_m, d.sqi_m, d.cs_m, d.and_or} =
                    pwdata_in[8:0];
            end else if (paddr_in == rxqt_pkg::A_THRESH) begin
                d.level_th = pwdata_in[7:0];
                d.preamble_quality_threshold = pwdata_in[11:8];
                d.sync_quality_threshold = pwdata_in[14:12];
                d.sync_word_length = pwdata_in[21:16];
            end else if (paddr_in == rxqt_pkg::A_TIMER) begin
                d.dur = pwdata_in[15:0];
            end else if (paddr_in == rxqt_pkg::A_IFOFS) begin
                d.if_ana = pwdata_in[7:0];
                d.if_dig = pwdata_in[15:8];
            end else if (paddr_in == rxqt_pkg::A_STATUS) begin
                d.st[4:1] = q.st[4:1] & ~pwdata_in[4:1];
            end
        end
        // new reception clears per-packet indicators
        if (rx_rise) begin
            d.pqi_cnt = 8'h0;
            d.pqi_peak = 8'h0;
            d.pv = 1'b0;
            d.sqi_peak = 6'h0;
            d.sqi_sec = 1'b0;
            d.sv = 1'b0;
            d.sh_cnt = 3'd0;
        end
        // carrier detect, static and dynamic, see R15 R16
        if (demod_in.level_valid) begin
            if (q.cs_mode == 2'd0) begin
                if (!q.cs && lvl > {1'b0, q.level_th}) begin
                    d.cs = 1'b1;
                end else if (q.cs && lvl + rxqt_pkg::CS_HYST <= {1'b0, q.level_th}) begin
                    d.cs = 1'b0;
                end
            end else if (!q.cs) begin
                d.cs_ref = (demod_in.level < q.cs_ref) ? demod_in.level : q.cs_ref;
                if (lvl > {1'b0, q.level_th} && lvl >= {1'b0, q.cs_ref} + step) begin
                    d.cs = 1'b1;
                    d.cs_ref = demod_in.level;
                end
            end else begin
                d.cs_ref = (demod_in.level > q.cs_ref) ? demod_in.level : q.cs_ref;
                if (lvl + step <= {1'b0, q.cs_ref}) begin
                    d.cs = 1'b0;
                    d.cs_ref = demod_in.level;
                end
            end
        end
        d.track = d.cs & ~q.cs;                 // tracking start, see R17
        d.st[rxqt_pkg::ST_CS] = d.cs;
        // preamble quality count and peak, see R18 R19
        if (demod_in.bit_valid && rx_active_in) begin
            d.last_bit = demod_in.bit_val;
            // works on the cleared values when a bit lands on rx entry
            if (demod_in.bit_val != q.last_bit) begin
                cnt = (d.pqi_cnt == rxqt_pkg::PQI_MAX) ? d.pqi_cnt
                    : d.pqi_cnt + rxqt_pkg::PQI_INC;
            end else begin
                cnt = (d.pqi_cnt >= rxqt_pkg::PQI_DEC) ? d.pqi_cnt - rxqt_pkg::PQI_DEC
                    : 8'h0;
            end
            d.pqi_cnt = cnt;
            if (cnt > d.pqi_peak) begin
                d.pqi_peak = cnt;
            end
            if (!d.pv && d.pqi_peak > {2'b00, q.preamble_quality_threshold, 2'b00}) begin
                d.pv = 1'b1;
                d.st[rxqt_pkg::ST_PV] = 1'b1;
            end
        end
        // sync correlation peak, see R20 R21
        if (demod_in.corr_valid && rx_active_in && q.sync_quality_check_enable) begin
            if (demod_in.corr > d.sqi_peak) begin
                d.sqi_peak = demod_in.corr;
                d.sqi_sec = demod_in.corr_sec;
            end
            if (!d.sv && {1'b0, demod_in.corr} >= sqi_need) begin
                d.sv = 1'b1;
                d.st[rxqt_pkg::ST_SV] = 1'b1;
            end
        end
        // level capture at sync end or abort command, see R13
        if (demod_in.sync_done || abort_command_in) begin
            d.cap_level = demod_in.level;
        end
        // rx timer, see R4 R5 R22
        case (q.tmr)
            rxqt_pkg::TMR_IDLE: begin
                if (rx_rise) begin
                    d.tmr = (!any_mask && !q.and_or) ? rxqt_pkg::TMR_NEVER : rxqt_pkg::TMR_RUN;
                    d.tmr_cnt = q.dur;
                end
            end
            rxqt_pkg::TMR_RUN: begin
                if (!rx_active_in || abort_command_in) begin
                    d.tmr = rxqt_pkg::TMR_IDLE;
                end else if (stop_cond) begin
                    d.tmr = rxqt_pkg::TMR_HALT;
                end else if (tick) begin
                    if (q.tmr_cnt == 16'h0) begin
                        // expiry aborts and discards, see R3 R13
                        d.tmr = rxqt_pkg::TMR_IDLE;
                        d.abort = 1'b1;
                        d.cap_level = demod_in.level;
                        d.st[rxqt_pkg::ST_TO] = 1'b1;
                    end else begin
                        d.tmr_cnt = q.tmr_cnt - 16'h1;
                    end
                end
            end
            default: begin
                if (!rx_active_in) begin
                    d.tmr = rxqt_pkg::TMR_IDLE;
                end
            end
        endcase
        // raw bytes into the rx fifo, msb first, see R10
        if (q.dmode == rxqt_pkg::DM_FIFO && rx_active_in && demod_in.bit_valid) begin
            d.sh = {q.sh[6:0], demod_in.bit_val};
            d.sh_cnt = d.sh_cnt + 3'd1;
            if (d.sh_cnt == 3'd0) begin
                d.fifo_wr = 1'b1;
                d.fifo_data = {q.sh[6:0], demod_in.bit_val};
                if (fifo_full_in) begin
                    d.st[rxqt_pkg::ST_OVF] = 1'b1;
                end
            end
        end
        // raw bits on gpio, data changes with the falling clock, see R11
        if (q.dmode == rxqt_pkg::DM_GPIO && rx_active_in && demod_in.bit_valid) begin
            d.gclk = 1'b0;
            d.gdata = demod_in.bit_val;
            d.gcnt = 3'(rxqt_pkg::DCLK_LOW_CYC - 1);
        end else if (!q.gclk) begin
            if (q.gcnt == 3'd0) begin
                d.gclk = 1'b1;
            end else begin
                d.gcnt = q.gcnt - 3'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    // sync-released reset gives every field a constant
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.sqi_m <= 1'b1;                    // sync mask alone, see R6
            q.sync_quality_check_enable <= 1'b1;
            q.sync_word_length <= rxqt_pkg::SYNC_WORD_LENGTH_RST;
            q.dur <= rxqt_pkg::TIMER_RST;
            q.tmr <= rxqt_pkg::TMR_IDLE;
            q.gclk <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // two-cycle apb transfer, write and read answer in the access phase
    assign pready_out = psel_in & penable_in;
    assign pslverr_out = psel_in & penable_in & (paddr_in[1:0] != 2'b00 ||
        paddr_in > rxqt_pkg::A_IF_DIG);
    assign prdata_out = q.prdata;
    assign fifo_wr_out = q.fifo_wr;
    assign fifo_data_out = q.fifo_data;
    assign gpio_data_out = q.gdata;
    assign gpio_clk_out = q.gclk;
    assign carrier_detect_out = q.cs;
    assign track_start_out = q.track;
    assign preamble_valid_out = q.pv;
    assign sync_valid_out = q.sv;
    assign rx_timeout_abort_out = q.abort;
    assign analog_if_offset_out = q.if_ana;
    assign digital_if_offset_out = q.if_dig;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n);

    expiry_from_run_a: assert property (q.abort |-> $past(q.tmr) == rxqt_pkg::TMR_RUN // see R3
        && q.tmr == rxqt_pkg::TMR_IDLE && q.st[rxqt_pkg::ST_TO])
        else $error("abort without running timer");
    never_expires_a: assert property (q.tmr == rxqt_pkg::TMR_NEVER |=> !q.abort) // see R4
        else $error("timeout in never mode");
    capture_on_expiry_a: assert property (q.abort |-> q.cap_level == $past(demod_in.level)) // see R13
        else $error("level not captured at expiry");
    cs_static_set_a: assert property (demod_in.level_valid && q.cs_mode == 2'd0 // see R15
        && !q.cs && demod_in.level > q.level_th |=> q.cs ##1 track_start_out == 1'b0)
        else $error("static carrier detect missed");
    cs_static_clr_a: assert property (demod_in.level_valid && q.cs_mode == 2'd0 // see R15
        && q.cs && {1'b0, demod_in.level} + rxqt_pkg::CS_HYST <= {1'b0, q.level_th} |=> !q.cs)
        else $error("static carrier detect not released");
    pqi_peak_a: assert property (q.pqi_peak >= q.pqi_cnt) // see R18
        else $error("preamble peak below count");
    pqi_valid_a: assert property ($rose(q.pv) |-> q.pqi_peak > {2'b00, q.preamble_quality_threshold, 2'b00}) // see R19
        else $error("preamble valid below threshold");
    sqi_valid_a: assert property ($rose(q.sv) |-> $past(q.sync_quality_check_enable) // see R20
        && {1'b0, q.sqi_peak} >= sqi_need)
        else $error("sync valid below threshold");
    timer_halt_a: assert property (q.tmr == rxqt_pkg::TMR_RUN && stop_cond // see R22
        && rx_active_in && !abort_command_in |=> q.tmr == rxqt_pkg::TMR_HALT [*2]
        or $past(rx_active_in, 1) == 1'b0 or !rx_active_in)
        else $error("timer not halted by stop condition");
    gpio_fall_a: assert property (demod_in.bit_valid && rx_active_in // see R11
        && q.dmode == rxqt_pkg::DM_GPIO
        |=> !gpio_clk_out && gpio_data_out == $past(demod_in.bit_val))
        else $error("gpio data not on falling clock");
    cov_timeout_c: cover property (q.abort);
    cov_halt_c: cover property (q.tmr == rxqt_pkg::TMR_HALT);
    cov_fifo_c: cover property (q.fifo_wr);
    cov_cs_c: cover property ($rose(q.cs));
endmodule
`default_nettype wire

// >>> verif/rxqt_core_test.sv
/*
 * rxqt_core_test: apb bench for the rx quality and timeout block.
 * Assumes rxqt_pkg and the host sink model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module rxqt_core_test;
    // ------------------------------
    // signals and instances
    // ------------------------------
    logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rx = 1'b0, abt = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwd = 32'h0, prd;
    logic prdy, perr, full, fwr, gclk, gdat, cd, pv, sv, toa, trk;
    logic [7:0] fdat, aofs, dofs, gb, fb;
    rxqt_pkg::rxqt_demod_s dm = '0;
    int failures = 0, cmp_count = 0, n, nt = 0;
    // clock
    always #25 clk = ~clk;
    // count carrier detect start pulses
    always @(posedge clk) if (trk === 1'b1) nt++;
    rxqt_core DUT (.clk_sys_in(clk), .arst_n_in(arst_n), .paddr_in(paddr), .psel_in(psel),
        .penable_in(pen), .pwrite_in(pwr), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr), .rx_active_in(rx), .abort_command_in(abt),
        .demod_in(dm), .fifo_full_in(full), .fifo_wr_out(fwr), .fifo_data_out(fdat),
        .gpio_data_out(gdat), .gpio_clk_out(gclk), .carrier_detect_out(cd),
        .track_start_out(trk), .preamble_valid_out(pv), .sync_valid_out(sv),
        .rx_timeout_abort_out(toa), .analog_if_offset_out(aofs), .digital_if_offset_out(dofs));
    rxqt_host_sink host (.clk_in(clk), .gpio_clk_in(gclk), .gpio_data_in(gdat),
        .fifo_wr_in(fwr), .fifo_data_in(fdat), .gpio_byte_out(gb), .fifo_byte_out(fb),
        .fifo_full_out(full));
    // ------------------------------
    // tasks
    // ------------------------------
    // verdict and end of run
    task automatic close_out;
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, bounded wait on pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int k;
        k = 0;
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1 && k < 20) begin
            k++;
            @(posedge clk);
        end
        if (prdy !== 1'b1) begin
            failures++;
            close_out();
        end
        r = prd;
        e = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r & m, x);
    endtask
    // demod strobe: 0 level, 1 bit, 2 correlation, 3 sync end
    task automatic dp(input logic [1:0] k, input logic [7:0] lv, input logic [6:0] x);
        dm <= '{level: lv, level_valid: k == 2'd0, bit_valid: k == 2'd1, bit_val: x[0],
            corr: x[5:0], corr_sec: x[6], corr_valid: k == 2'd2, sync_done: k == 2'd3};
        @(posedge clk);
        dm <= '{level: lv, bit_val: x[0], corr: x[5:0], corr_sec: x[6], default: '0};
        repeat (2) @(posedge clk);
    endtask
    // fresh rx entry, count cycles to a timeout abort
    task automatic rx_run(input int cyc);
        rx <= 1'b0;
        @(posedge clk);
        rx <= 1'b1;
        n = 0;
        while (toa !== 1'b1 && n < cyc) begin
            @(posedge clk);
            n++;
        end
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        logic [11:0] seq;
        seq = 12'h575;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(rxqt_pkg::A_CTRL, 32'hffffffff, 32'h44);
        rd(rxqt_pkg::A_THRESH, 32'h3f0000, 32'h200000);
        apb(1'b0, 8'h20, 32'h0, r, e);
        chk(r, 32'h0);
        chk(e, 1);
        wr(rxqt_pkg::A_IFOFS, 32'h3a5c);
        chk({dofs, aofs}, 32'h3a5c);
        rd(rxqt_pkg::A_IF_DIG, 32'hffffffff, 32'h1f644);
        wr(rxqt_pkg::A_TIMER, 32'h2);
        wr(rxqt_pkg::A_THRESH, 32'h201150);
        dp(0, 8'h60, 0);
        chk(cd, 1);
        wr(rxqt_pkg::A_CTRL, 32'h41);
        rx_run(200);
        chk(n >= 40 && n <= 66, 1);
        rd(rxqt_pkg::A_STATUS, 32'h8, 32'h8);
        wr(rxqt_pkg::A_CTRL, 32'h40);
        rx_run(200);
        chk(n, 200);
        rd(rxqt_pkg::A_STATUS, 32'h60, 32'h60);
        wr(rxqt_pkg::A_CTRL, 32'h42);
        rx_run(200);
        chk(n, 200);
        rd(rxqt_pkg::A_STATUS, 32'h60, 32'h40);
        for (int s = 0; s < 2; s++) begin
            wr(rxqt_pkg::A_CTRL, 32'h4a | s);
            rx_run(200);
            chk(n > 66, s);
        end
        for (int i = 11; i >= 0; i--) begin
            dp(1, 8'h60, {6'h0, seq[i]});
            if (i == 7) chk(pv, 0);
        end
        chk(pv, 1);
        rd(rxqt_pkg::A_LEVEL, 32'hff0000, 32'h50000);
        dp(2, 8'h60, 7'h1d);
        chk(sv, 0);
        dp(2, 8'h60, 7'h5e);
        chk(sv, 1);
        rd(rxqt_pkg::A_LEVEL, 32'h7f000000, 32'h5e000000);
        dp(0, 8'h77, 0);
        dp(3, 8'h77, 0);
        rd(rxqt_pkg::A_LEVEL, 32'hffff, 32'h7777);
        dp(0, 8'h4e, 0);
        chk(cd, 1);
        dp(0, 8'h4b, 0);
        chk(cd, 0);
        dp(0, 8'h33, 0);
        abt <= 1'b1;
        @(posedge clk);
        abt <= 1'b0;
        repeat (2) @(posedge clk);
        rd(rxqt_pkg::A_LEVEL, 32'hff, 32'h33);
        // dynamic mode 1: rise of 6 sets, equal fall clears, smaller rise ignored
        wr(rxqt_pkg::A_CTRL, 32'h50);
        for (int i = 3; i >= 0; i--) begin
            dp(0, 8'(32'h57515557 >> (8 * i)), 0);
            chk(cd, i % 3 == 0);
        end
        for (int m = 1; m < 3; m++) begin
            wr(rxqt_pkg::A_CTRL, 32'h40 | (m << 7));
            rx_run(4);
            for (int i = 7; i >= 0; i--) begin
                dp(1, 8'h60, {6'h0, seq[i]});
                repeat (6) @(posedge clk);
            end
            chk(m == 1 ? fb : gb, 8'h75);
        end
        chk(nt, 3);
        close_out();
    end
endmodule
`default_nettype wire

// >>> verif/rxqt_host_sink.sv
/*
 * rxqt_host_sink: host side of the raw receive data paths.
 * Assumes gpio data changes on the falling edge of the data clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rxqt_host_sink (
    input wire logic clk_in,
    input wire logic gpio_clk_in,
    input wire logic gpio_data_in,
    input wire logic fifo_wr_in,
    input wire logic [7:0] fifo_data_in,
    output logic [7:0] gpio_byte_out,
    output logic [7:0] fifo_byte_out,
    output logic fifo_full_out
);
    // ------------------------------
    // sampling
    // ------------------------------
    // host drains the fifo at once
    assign fifo_full_out = 1'b0;
    // data is settled at the rising clock edge
    always @(posedge gpio_clk_in) gpio_byte_out <= {gpio_byte_out[6:0], gpio_data_in};
    // keep each byte as it is written
    always @(posedge clk_in) if (fifo_wr_in) fifo_byte_out <= fifo_data_in;
endmodule
`default_nettype wire
